//--- rtl/cbar_pkg.sv
// Package for the circular bus auto-reset chain: timing counts and states.
// Assumes a single 100 MHz clock shared by the watchdog and the board ends.
package cbar_pkg;
	localparam int unsigned CLK_MHZ = 100;
	// Supervision pulse period driven by the watchdog, in microseconds
	localparam int unsigned PULSE_PERIOD_US = 10;
	localparam int unsigned PULSE_PERIOD_CYC = PULSE_PERIOD_US * CLK_MHZ;
	// Default return timeout, in microseconds
	localparam int unsigned TIMEOUT_US = 40;
	localparam int unsigned TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
	// Fixed reset hold time, in microseconds
	localparam int unsigned RST_HOLD_US = 20;
	localparam int unsigned RST_HOLD_CYC = RST_HOLD_US * CLK_MHZ;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] TIMEOUT_DEF = 16'(TIMEOUT_CYC);
	localparam logic [CNT_W-1:0] PERIOD_LAST = 16'(PULSE_PERIOD_CYC - 1);
	localparam logic [CNT_W-1:0] HOLD_LAST = 16'(RST_HOLD_CYC - 1);

	typedef enum logic [1:0] {
		CBAR_MON = 2'b00,
		CBAR_RST = 2'b01
	} cbar_state_t;

	typedef enum logic [1:0] {
		CBAR_ACTIVE = 2'b00,
		CBAR_PASSIVE = 2'b01,
		CBAR_FILLER = 2'b10
	} cbar_kind_t;
endpackage

//--- rtl/cbar_if.sv
// Interface for the supervision chain segment and the bus-wide reset line.
// Assumes the bench joins watchdog and board ends through this interface.
interface cbar_if;
	logic sup_out;
	logic sup_ret;
	logic bus_rst_n;
	logic sup_in;
	logic sup_fwd;
	modport ctl (output sup_out, input sup_ret, output bus_rst_n);
	modport brd (input sup_in, output sup_fwd, input bus_rst_n);
endinterface

//--- rtl/cbar_watchdog.sv
// Control board watchdog of the circular auto-reset chain.
// Assumes boards and the bus termination return the pulse to sup_ret.
module cbar_watchdog (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic CE,
	input wire logic [cbar_pkg::CNT_W-1:0] TIMEOUT,
	output logic RESETTING,
	output logic TRIP,
	cbar_if.ctl BUS
);
	import cbar_pkg::*;

	cbar_state_t state_ff;
	logic [CNT_W-1:0] per_ff;
	logic [CNT_W-1:0] wait_ff;
	logic [CNT_W-1:0] hold_ff;
	logic pulse_ff;
	logic ret_s1_ff;
	logic ret_s2_ff;
	logic ret_s3_ff;
	logic rst_n_ff;
	logic resetting_ff;
	logic trip_ff;
	logic ret_edge;
	logic timeout_hit;

	// Return path is an external pin: three stages, edge when stages two and three differ
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ret_s1_ff <= 1'b0;
			ret_s2_ff <= 1'b0;
			ret_s3_ff <= 1'b0;
		end else if (CE) begin
			ret_s1_ff <= BUS.sup_ret;
			ret_s2_ff <= ret_s1_ff;
			ret_s3_ff <= ret_s2_ff;
		end
	end

	assign ret_edge = ret_s2_ff != ret_s3_ff;
	assign timeout_hit = (TIMEOUT == 16'h0000) ? (wait_ff >= TIMEOUT_DEF) : (wait_ff >= TIMEOUT);

	// Free-running toggle pulse onto the bus; stopped while reset is held
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			per_ff <= 16'h0000;
			pulse_ff <= 1'b0;
		end else if (CE) begin
			if (state_ff == CBAR_RST) begin
				per_ff <= 16'h0000;
				pulse_ff <= 1'b0;
			end else if (per_ff == PERIOD_LAST) begin
				per_ff <= 16'h0000;
				pulse_ff <= ~pulse_ff;
			end else begin
				per_ff <= per_ff + 16'h0001;
			end
		end
	end

	// Supervision state: monitor for return activity, or hold bus reset
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_ff <= CBAR_MON;
			wait_ff <= 16'h0000;
			hold_ff <= 16'h0000;
			trip_ff <= 1'b0;
		end else if (CE) begin
			trip_ff <= 1'b0;
			unique case (state_ff)
				CBAR_MON: begin
					if (ret_edge) begin
						wait_ff <= 16'h0000;
					end else if (timeout_hit) begin
						state_ff <= CBAR_RST;
						hold_ff <= 16'h0000;
						trip_ff <= 1'b1;
					end else begin
						wait_ff <= wait_ff + 16'h0001;
					end
				end
				CBAR_RST: begin
					if (hold_ff == HOLD_LAST) begin
						state_ff <= CBAR_MON;
						wait_ff <= 16'h0000;
					end else begin
						hold_ff <= hold_ff + 16'h0001;
					end
				end
				default: begin
					state_ff <= CBAR_MON;
				end
			endcase
		end
	end

	// Bus reset is low during the hold; repeats while the chain stays open
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rst_n_ff <= 1'b0;
			resetting_ff <= 1'b1;
		end else if (CE) begin
			rst_n_ff <= (state_ff != CBAR_RST);
			resetting_ff <= (state_ff == CBAR_RST);
		end
	end

	assign BUS.sup_out = pulse_ff;
	assign BUS.bus_rst_n = rst_n_ff;
	assign RESETTING = resetting_ff;
	assign TRIP = trip_ff;
endmodule

//--- rtl/cbar_board.sv
// Function board end of the chain: active, passive or slot filler.
// Assumes the previous board's output arrives on sup_in, same clock.
module cbar_board (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic CE,
	input wire cbar_pkg::cbar_kind_t KIND,
	input wire logic PROG_OK,
	output logic RUNNING,
	output logic FWD,
	cbar_if.brd BUS
);
	import cbar_pkg::*;

	logic in_s1_ff;
	logic in_s2_ff;
	logic in_s3_ff;
	logic fwd_ff;
	logic run_ff;
	logic rst_s1_ff;
	logic rst_s2_ff;
	logic rst_s3_ff;

	// Pin inputs pass three stages
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			in_s1_ff <= 1'b0;
			in_s2_ff <= 1'b0;
			in_s3_ff <= 1'b0;
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
			rst_s3_ff <= 1'b0;
		end else if (CE) begin
			in_s1_ff <= BUS.sup_in;
			in_s2_ff <= in_s1_ff;
			in_s3_ff <= in_s2_ff;
			rst_s1_ff <= BUS.bus_rst_n;
			rst_s2_ff <= rst_s1_ff;
			rst_s3_ff <= rst_s2_ff;
		end
	end

	// Program restarts after bus reset release
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			run_ff <= 1'b0;
		end else if (CE) begin
			if (!rst_s2_ff && !rst_s3_ff) begin
				run_ff <= 1'b0;
			end else if (rst_s2_ff && rst_s3_ff) begin
				run_ff <= 1'b1;
			end
		end
	end

	// Active boards forward the pulse only while running and healthy
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			fwd_ff <= 1'b0;
		end else if (CE) begin
			if (run_ff && PROG_OK && (in_s2_ff == in_s3_ff)) begin
				fwd_ff <= in_s3_ff;
			end else if (!(run_ff && PROG_OK)) begin
				fwd_ff <= 1'b0;
			end
		end
	end

	// Passive and filler boards bridge input to output directly
	assign BUS.sup_fwd = (KIND == CBAR_ACTIVE) ? fwd_ff : BUS.sup_in;
	assign FWD = fwd_ff;
	assign RUNNING = run_ff;
endmodule

//--- test/cbar_monitor.sv
// Checker on the chain and bus reset signals.
// Assumes one instance beside the interface, same clock.
module cbar_monitor
	import cbar_pkg::*;
#(parameter int TO = 1500) (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic sup_out,
	input wire logic sup_ret,
	input wire logic bus_rst_n
);
	timeunit 1ns;
	timeprecision 1ps;
	int low_ff, idle_ff;
	logic ret_ff;
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) low_ff <= 0;
		else low_ff <= bus_rst_n ? 0 : low_ff + 1;
	end
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) ret_ff <= 1'b0;
		else ret_ff <= sup_ret;
	end
	// Cycles without return activity while monitoring
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) idle_ff <= 0;
		else idle_ff <= (!bus_rst_n || sup_ret != ret_ff) ? 0 : idle_ff + 1;
	end
	AST_HOLD_LEN: assert property ($rose(bus_rst_n) && low_ff > 1 |-> low_ff == RST_HOLD_CYC)
		else $error("reset hold length wrong");
	AST_HOLD_MIN: assert property ($fell(bus_rst_n) |=> !bus_rst_n [*8])
		else $error("reset released early");
	AST_QUIET_RST: assert property (!bus_rst_n && !$past(bus_rst_n) |-> !sup_out)
		else $error("pulse driven during reset");
	AST_TRIP_BOUND: assert property (bus_rst_n |-> idle_ff <= TO + 8)
		else $error("open chain not reset");
	AST_NO_EARLY: assert property ($fell(bus_rst_n) |-> idle_ff >= TO)
		else $error("reset while chain alive");
	AST_PULSE_GAP: assert property (bus_rst_n && $past(bus_rst_n) && $changed(sup_out) |=> $stable(sup_out) [*8])
		else $error("pulse toggles too fast");
endmodule

//--- test/cbar_tb_top.sv
// Bench joining watchdog and one board through the chain interface.
// Assumes the termination loops the board output back to the watchdog.
module cbar_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import cbar_pkg::*;
	logic CLK, NRST, prog_ok, running, trip, resetting, seen, fwd;
	cbar_kind_t kind;
	int bad_count, n_compared, cyc, trips, n;
	cbar_if bus();
	assign bus.sup_in = bus.sup_out;
	assign bus.sup_ret = bus.sup_fwd;
	cbar_watchdog cbar_watchdog_inst (.CLK(CLK), .NRST(NRST), .CE(1'b1), .TIMEOUT(16'h05dc),
		.RESETTING(resetting), .TRIP(trip), .BUS(bus.ctl));
	cbar_board cbar_board_inst (.CLK(CLK), .NRST(NRST), .CE(1'b1), .KIND(kind), .PROG_OK(prog_ok),
		.RUNNING(running), .FWD(fwd), .BUS(bus.brd));
	cbar_monitor #(.TO(1500)) cbar_monitor_inst (.CLK(CLK), .NRST(NRST), .sup_out(bus.sup_out),
		.sup_ret(bus.sup_ret), .bus_rst_n(bus.bus_rst_n));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("Counts: %0d bad of %0d", bad_count, n_compared);
		if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic wait_lvl(input logic v);
		for (n = 0; n < 4000 && bus.bus_rst_n !== v; n++) @(posedge CLK);
		chk(16'(bus.bus_rst_n), 16'(v));
	endtask
	initial begin
		CLK = 0;
		forever #5 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cyc++;
		if (trip === 1'b1) trips++;
		if (NRST && bus.bus_rst_n !== 1'b1) seen = 1;
		if (cyc == 40000) begin
			bad_count++;
			report_and_stop();
		end
	end
	initial begin
		NRST = 0;
		prog_ok = 1;
		kind = CBAR_ACTIVE;
		repeat (10) @(posedge CLK);
		NRST <= 1;
		repeat (20) @(posedge CLK);
		for (int k = 0; k < 3; k++) begin
			kind <= cbar_kind_t'(k);
			seen = 0;
			repeat (6000) @(posedge CLK);
			chk(16'(seen), 16'h0000);
			chk(16'(running), 16'h0001);
		end
		// Only an active board can break the chain
		kind <= CBAR_ACTIVE;
		prog_ok <= 0;
		trips = 0;
		wait_lvl(0);
		chk(16'(trips), 16'h0001);
		repeat (10) @(posedge CLK);
		chk(16'(running), 16'h0000);
		chk(16'(resetting), 16'h0001);
		chk(16'(fwd), 16'h0000);
		wait_lvl(1);
		chk(16'(n + 10), 16'(RST_HOLD_CYC));
		wait_lvl(0);
		chk(16'(trips), 16'h0002);
		prog_ok <= 1;
		wait_lvl(1);
		seen = 0;
		repeat (6000) @(posedge CLK);
		chk(16'(seen), 16'h0000);
		chk(16'(running), 16'h0001);
		report_and_stop();
	end
endmodule
